// *** pkg/mpcl_regs.svh ***
// Register map, fields, reset values and timing of the pin loader
// Assumes a 40 MHz clock and a 32-bit APB register port
`ifndef MPCL_REGS_SVH
`define MPCL_REGS_SVH

// ***********************************************
// Register offsets
// ***********************************************
`define MPCL_OFF_CTRL     8'h00
`define MPCL_OFF_STATUS   8'h04
`define MPCL_OFF_ADDR     8'h08
`define MPCL_OFF_VOUT     8'h0c
`define MPCL_OFF_VCEIL    8'h10
`define MPCL_OFF_SSCFG    8'h14
`define MPCL_OFF_UVTH     8'h18
`define MPCL_OFF_OVTH     8'h1c
`define MPCL_OFF_IRQSTAT  8'h20
`define MPCL_OFF_IRQMASK  8'h24

// ***********************************************
// Fields
// ***********************************************
`define MPCL_CTRL_RESTORE 0
`define MPCL_CTRL_SAVE    1
`define MPCL_EV_LOADED    0
`define MPCL_EV_UNDER     1
`define MPCL_EV_OVER      2
`define MPCL_EV_CLAMP     3
`define MPCL_NEV          4
`define MPCL_ST_KIND_LSB  4
`define MPCL_ST_STORE     10
`define MPCL_SAVE_SS_LSB  16

// ***********************************************
// Pins, reset values, timing
// ***********************************************
`define MPCL_NPIN         3
`define MPCL_PIN_ADDR     0
`define MPCL_PIN_VOLTAGE_SELECT_PIN     1
`define MPCL_PIN_SS       2
`define MPCL_SELW         5
`define MPCL_ADDR_BASE    7'h20
`define MPCL_ADDR_RES_OFS 7'h03
`define MPCL_UV_RESET     16'h0000
`define MPCL_OV_RESET     16'hffff
`define MPCL_CEIL_NUM     11
`define MPCL_CEIL_DEN     10
`define MPCL_CLK_PERIOD_NS 25
`define MPCL_US_CYCLES    (1000 / `MPCL_CLK_PERIOD_NS)
`define MPCL_MEMCHECK_MS  10

`endif

// *** pkg/mpcl_pkg.sv ***
// Types of the pin configuration loader
// Assumes mpcl_regs.svh for sizes
`default_nettype none
`include "mpcl_regs.svh"
package mpcl_pkg;
  typedef enum logic [1:0] {
    K_LOW  = 2'b00,
    K_OPEN = 2'b01,
    K_HIGH = 2'b10,
    K_RES  = 2'b11
  } mpcl_kind_t;

  typedef enum logic [1:0] {
    S_MEMCHECK  = 2'b00,
    S_PINSAMPLE = 2'b01,
    S_PINLOAD   = 2'b10,
    S_READY     = 2'b11
  } mpcl_state_t;
endpackage
`default_nettype wire

// *** pkg/mpcl_pin_if.sv ***
// Sample strobe and decoded pin results between loader and classifier
// Assumes both ends on the same clock
`default_nettype none
`include "mpcl_regs.svh"
interface mpcl_pin_if;
  logic                                 sample;
  logic [`MPCL_NPIN*2-1:0]              kind;
  logic [`MPCL_NPIN*`MPCL_SELW-1:0]     sel;
  modport loader     (output sample, input kind, input sel);
  modport classifier (input sample, output kind, output sel);
endinterface
`default_nettype wire

// *** core/mpcl_pin_classifier.sv ***
// Synchronises and classifies the multi-mode configuration pins
// Assumes level detectors and a resistor code (0 = none) per pin
`default_nettype none
`include "mpcl_regs.svh"
module mpcl_pin_classifier
  import mpcl_pkg::*;
(
  input  wire logic                              clock,
  input  wire logic                              reset,
  input  wire logic [`MPCL_NPIN-1:0]             pinLowLvl,
  input  wire logic [`MPCL_NPIN-1:0]             pinHighLvl,
  input  wire logic [`MPCL_NPIN*`MPCL_SELW-1:0]  pinResCode,
  mpcl_pin_if.classifier                         pif
);
  typedef struct packed {
    logic [`MPCL_NPIN-1:0]             low1;
    logic [`MPCL_NPIN-1:0]             low2;
    logic [`MPCL_NPIN-1:0]             high1;
    logic [`MPCL_NPIN-1:0]             high2;
    logic [`MPCL_NPIN*`MPCL_SELW-1:0]  res1;
    logic [`MPCL_NPIN*`MPCL_SELW-1:0]  res2;
    logic [`MPCL_NPIN*2-1:0]           kind;
    logic [`MPCL_NPIN*`MPCL_SELW-1:0]  sel;
  } mpcl_cls_t;

  mpcl_cls_t                         q;
  mpcl_cls_t                         d;
  logic [`MPCL_NPIN*2-1:0]           classKind;
  logic [`MPCL_NPIN*`MPCL_SELW-1:0]  classSel;

  // ***********************************************
  // Classification per pin
  // ***********************************************
  for (genvar i = 0; i < `MPCL_NPIN; i++) begin : g_pin
    logic [`MPCL_SELW-1:0] code;
    assign code = q.res2[i*`MPCL_SELW +: `MPCL_SELW];
    // A measured resistor overrides the level detectors
    always_comb begin
      if (code != '0) begin
        classKind[i*2 +: 2]                   = K_RES;
        classSel[i*`MPCL_SELW +: `MPCL_SELW]  = code - 5'h01;
      end else if (q.low2[i]) begin
        classKind[i*2 +: 2]                   = K_LOW;
        classSel[i*`MPCL_SELW +: `MPCL_SELW]  = 5'h00;
      end else if (q.high2[i]) begin
        classKind[i*2 +: 2]                   = K_HIGH;
        classSel[i*`MPCL_SELW +: `MPCL_SELW]  = 5'h02;
      end else begin
        classKind[i*2 +: 2]                   = K_OPEN;
        classSel[i*`MPCL_SELW +: `MPCL_SELW]  = 5'h01;
      end
    end
  end

  // ***********************************************
  // State
  // ***********************************************
  always_comb begin
    d       = q;
    d.low1  = pinLowLvl;
    d.low2  = q.low1;
    d.high1 = pinHighLvl;
    d.high2 = q.high1;
    d.res1  = pinResCode;
    d.res2  = q.res1;
    // Latched only on a sample; later drift is not seen
    if (pif.sample) begin
      d.kind = classKind;
      d.sel  = classSel;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pif.kind = q.kind;
  assign pif.sel  = q.sel;
endmodule // mpcl_pin_classifier
`default_nettype wire

// *** core/mpcl_loader.sv ***
// Pin configuration loader: start-up sequence, pin decode, APB registers
// Assumes analog front end pins, a persistent store macro and an APB master
`default_nettype none
`include "mpcl_regs.svh"
module mpcl_loader
  import mpcl_pkg::*;
#(
  parameter int MEMCHECK_US = `MPCL_MEMCHECK_MS * 1000
) (
  input  wire logic                              clock,
  input  wire logic                              reset,
  input  wire logic [7:0]                        paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [`MPCL_NPIN-1:0]             pinLowLvl,
  input  wire logic [`MPCL_NPIN-1:0]             pinHighLvl,
  input  wire logic [`MPCL_NPIN*`MPCL_SELW-1:0]  pinResCode,
  input  wire logic                              enableReqPin,
  input  wire logic [15:0]                       voutMeasMv,
  input  wire logic                              storeHasData,
  input  wire logic [31:0]                       storeRdData,
  output logic                                   storeWrite,
  output logic      [31:0]                       storeWrData,
  output logic      [6:0]                        busAddress,
  output logic      [15:0]                       voutSetMv,
  output logic      [15:0]                       voutCeilMv,
  output logic      [7:0]                        softStartCfg,
  output logic                                   convertEnable,
  output logic                                   configReady,
  output logic                                   irq
);
  // ***********************************************
  // Tables and helpers
  // ***********************************************
  localparam logic [15:0] VOUT_STRAP_MV [3] = '{16'h04b0, 16'h05dc, 16'h0ce4};
  localparam logic [15:0] VOUT_RES_MV [31] = '{
    16'h0258, 16'h02bc, 16'h02ee, 16'h0320, 16'h0384, 16'h03e8, 16'h044c, 16'h04b0,
    16'h04e2, 16'h0514, 16'h0578, 16'h05dc, 16'h0640, 16'h06a4, 16'h0708, 16'h076c,
    16'h07d0, 16'h0834, 16'h0898, 16'h08fc, 16'h0960, 16'h09c4, 16'h0a28, 16'h0a8c,
    16'h0af0, 16'h0b54, 16'h0bb8, 16'h0c1c, 16'h0c80, 16'h0ce4, 16'h1388};

  typedef struct packed {
    mpcl_state_t           state;
    logic [5:0]            usDiv;
    logic [13:0]           usCnt;
    logic [1:0]            enSync;
    logic [6:0]            busAddr;
    logic [15:0]           voutMv;
    logic [15:0]           ceilMv;
    logic [7:0]            ssCfg;
    logic [15:0]           uvMv;
    logic [15:0]           ovMv;
    logic [`MPCL_NEV-1:0]  irqStat;
    logic [`MPCL_NEV-1:0]  irqMask;
    logic [31:0]           rdData;
    logic                  rdErr;
    logic                  storeWr;
    logic [31:0]           storeData;
    logic                  sample;
  } mpcl_core_t;

  localparam mpcl_core_t CORE_RESET = '{
    state: S_MEMCHECK, usDiv: '0, usCnt: '0, enSync: '0, busAddr: `MPCL_ADDR_BASE,
    voutMv: '0, ceilMv: '0, ssCfg: '0, uvMv: `MPCL_UV_RESET, ovMv: `MPCL_OV_RESET,
    irqStat: '0, irqMask: '0, rdData: '0, rdErr: 1'b0, storeWr: 1'b0,
    storeData: '0, sample: 1'b0};

  mpcl_core_t            q;
  mpcl_core_t            d;
  mpcl_pin_if            pif ();
  logic [`MPCL_NEV-1:0]  evSet;
  logic [`MPCL_NEV-1:0]  evClr;
  logic                  isSetup;
  logic                  isAccess;
  logic                  mapped;

  function automatic logic mpclHit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  function automatic logic [1:0] pinKind(input logic [`MPCL_NPIN*2-1:0] kinds, input int idx);
    return kinds[idx*2 +: 2];
  endfunction

  function automatic logic [4:0] pinSel(input logic [`MPCL_NPIN*`MPCL_SELW-1:0] sels,
                                        input int idx);
    return sels[idx*`MPCL_SELW +: `MPCL_SELW];
  endfunction

  // Strap picks one of three, resistor one of 31
  function automatic logic [15:0] voutFromPin(input logic [1:0] kind, input logic [4:0] sel);
    logic [15:0] mv;
    mv = 16'h0000;
    if (kind == K_RES) begin
      if (sel < 5'd31) begin
        mv = VOUT_RES_MV[sel];
      end
    end else if (sel < 5'd3) begin
      mv = VOUT_STRAP_MV[sel[1:0]];
    end
    return mv;
  endfunction

  function automatic logic [15:0] ceilFromVout(input logic [15:0] mv);
    logic [19:0] prod;
    prod = 20'(mv) * 20'(`MPCL_CEIL_NUM);
    return 16'(prod / 20'(`MPCL_CEIL_DEN));
  endfunction

  // ***********************************************
  // Pin classifier
  // ***********************************************
  mpcl_pin_classifier u_cls (
    .clock      (clock),
    .reset      (reset),
    .pinLowLvl  (pinLowLvl),
    .pinHighLvl (pinHighLvl),
    .pinResCode (pinResCode),
    .pif        (pif)
  );

  assign pif.sample = q.sample;

  // ***********************************************
  // Sequencer, monitor and register file
  // ***********************************************
  assign isSetup  = psel & ~penable;
  assign isAccess = psel & penable;
  assign mapped   = mpclHit(paddr, `MPCL_OFF_CTRL) | mpclHit(paddr, `MPCL_OFF_STATUS) |
                    mpclHit(paddr, `MPCL_OFF_ADDR) | mpclHit(paddr, `MPCL_OFF_VOUT) |
                    mpclHit(paddr, `MPCL_OFF_VCEIL) | mpclHit(paddr, `MPCL_OFF_SSCFG) |
                    mpclHit(paddr, `MPCL_OFF_UVTH) | mpclHit(paddr, `MPCL_OFF_OVTH) |
                    mpclHit(paddr, `MPCL_OFF_IRQSTAT) | mpclHit(paddr, `MPCL_OFF_IRQMASK);

  always_comb begin
    d         = q;
    d.sample  = 1'b0;
    d.storeWr = 1'b0;
    evSet     = '0;
    evClr     = '0;
    d.enSync  = {q.enSync[0], enableReqPin};

    unique case (q.state)
      // Memory check holds off bus and enable
      S_MEMCHECK: begin
        if (q.usDiv == 6'(`MPCL_US_CYCLES - 1)) begin
          d.usDiv = '0;
          if (q.usCnt == 14'(MEMCHECK_US - 1)) begin
            d.state  = S_PINSAMPLE;
            d.sample = 1'b1;
          end else begin
            d.usCnt = q.usCnt + 14'h0001;
          end
        end else begin
          d.usDiv = q.usDiv + 6'h01;
        end
      end
      S_PINSAMPLE: begin
        d.state = S_PINLOAD;
      end
      S_PINLOAD: begin
        d.busAddr = (pinKind(pif.kind, `MPCL_PIN_ADDR) == K_RES) ?
                    `MPCL_ADDR_BASE + `MPCL_ADDR_RES_OFS +
                    7'(pinSel(pif.sel, `MPCL_PIN_ADDR)) :
                    `MPCL_ADDR_BASE + 7'(pinSel(pif.sel, `MPCL_PIN_ADDR));
        d.ceilMv  = ceilFromVout(voutFromPin(pinKind(pif.kind, `MPCL_PIN_VOLTAGE_SELECT_PIN),
                                             pinSel(pif.sel, `MPCL_PIN_VOLTAGE_SELECT_PIN)));
        // Saved settings beat straps; the ceiling never does
        if (storeHasData) begin
          d.voutMv = storeRdData[15:0];
          d.ssCfg  = storeRdData[`MPCL_SAVE_SS_LSB +: 8];
        end else begin
          d.voutMv = voutFromPin(pinKind(pif.kind, `MPCL_PIN_VOLTAGE_SELECT_PIN),
                                 pinSel(pif.sel, `MPCL_PIN_VOLTAGE_SELECT_PIN));
          d.ssCfg  = {1'b0, pinKind(pif.kind, `MPCL_PIN_SS),
                      pinSel(pif.sel, `MPCL_PIN_SS)};
        end
        d.state = S_READY;
        evSet[`MPCL_EV_LOADED] = 1'b1;
      end
      S_READY: begin
        evSet[`MPCL_EV_UNDER] = voutMeasMv < q.uvMv;
        evSet[`MPCL_EV_OVER]  = voutMeasMv > q.ovMv;
      end
    endcase

    // Reads captured at setup so prdata comes from a flop
    if (isSetup) begin
      d.rdData = '0;
      d.rdErr  = ~mapped | (q.state != S_READY);
      if (q.state == S_READY) begin
        if (mpclHit(paddr, `MPCL_OFF_STATUS)) begin
          d.rdData[1:0] = q.state;
          d.rdData[`MPCL_ST_KIND_LSB +: `MPCL_NPIN*2] = pif.kind;
          d.rdData[`MPCL_ST_STORE] = storeHasData;
        end
        if (mpclHit(paddr, `MPCL_OFF_ADDR)) begin
          d.rdData[6:0] = q.busAddr;
        end
        if (mpclHit(paddr, `MPCL_OFF_VOUT)) begin
          d.rdData[15:0] = q.voutMv;
        end
        if (mpclHit(paddr, `MPCL_OFF_VCEIL)) begin
          d.rdData[15:0] = q.ceilMv;
        end
        if (mpclHit(paddr, `MPCL_OFF_SSCFG)) begin
          d.rdData[7:0] = q.ssCfg;
        end
        if (mpclHit(paddr, `MPCL_OFF_UVTH)) begin
          d.rdData[15:0] = q.uvMv;
        end
        if (mpclHit(paddr, `MPCL_OFF_OVTH)) begin
          d.rdData[15:0] = q.ovMv;
        end
        if (mpclHit(paddr, `MPCL_OFF_IRQSTAT)) begin
          d.rdData[`MPCL_NEV-1:0] = q.irqStat;
        end
        if (mpclHit(paddr, `MPCL_OFF_IRQMASK)) begin
          d.rdData[`MPCL_NEV-1:0] = q.irqMask;
        end
      end
    end

    // Address and ceiling have no write path
    if (isAccess && pwrite && q.state == S_READY) begin
      if (mpclHit(paddr, `MPCL_OFF_CTRL)) begin
        if (pwdata[`MPCL_CTRL_SAVE]) begin
          d.storeWr   = 1'b1;
          d.storeData = {8'h00, q.ssCfg, q.voutMv};
        end
        if (pwdata[`MPCL_CTRL_RESTORE]) begin
          d.state = S_MEMCHECK;
          d.usDiv = '0;
          d.usCnt = '0;
        end
      end
      if (mpclHit(paddr, `MPCL_OFF_VOUT)) begin
        // Host requests above the ceiling are clamped and flagged
        if (pwdata[15:0] > q.ceilMv) begin
          d.voutMv = q.ceilMv;
          evSet[`MPCL_EV_CLAMP] = 1'b1;
        end else begin
          d.voutMv = pwdata[15:0];
        end
      end
      if (mpclHit(paddr, `MPCL_OFF_SSCFG)) begin
        d.ssCfg = pwdata[7:0];
      end
      if (mpclHit(paddr, `MPCL_OFF_UVTH)) begin
        d.uvMv = pwdata[15:0];
      end
      if (mpclHit(paddr, `MPCL_OFF_OVTH)) begin
        d.ovMv = pwdata[15:0];
      end
      if (mpclHit(paddr, `MPCL_OFF_IRQSTAT)) begin
        evClr = pwdata[`MPCL_NEV-1:0];
      end
      if (mpclHit(paddr, `MPCL_OFF_IRQMASK)) begin
        d.irqMask = pwdata[`MPCL_NEV-1:0];
      end
    end

    // A new event beats a clear in the same cycle
    d.irqStat = (q.irqStat & ~evClr) | evSet;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign pready        = isAccess;
  assign prdata        = q.rdData;
  assign pslverr       = q.rdErr & isAccess;
  assign storeWrite    = q.storeWr;
  assign storeWrData   = q.storeData;
  assign busAddress    = q.busAddr;
  assign voutSetMv     = q.voutMv;
  assign voutCeilMv    = q.ceilMv;
  assign softStartCfg  = q.ssCfg;
  assign configReady   = q.state == S_READY;
  assign convertEnable = q.enSync[1] & (q.state == S_READY);
  assign irq           = |(q.irqStat & q.irqMask);
endmodule // mpcl_loader
`default_nettype wire

// *** dv/mpcl_front_model.sv ***
// Model of the pin front end and the persistent store
// Assumes pin kinds and codes from the bench
`default_nettype none
`include "mpcl_regs.svh"
module mpcl_front_model
  import mpcl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [5:0]  pinKind,
  input  wire logic [14:0] pinCode,
  input  wire logic        storeWrite,
  input  wire logic [31:0] storeWrData,
  output logic      [2:0]  pinLowLvl,
  output logic      [2:0]  pinHighLvl,
  output logic      [14:0] pinResCode,
  output logic             storeHasData,
  output logic      [31:0] storeRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Pin levels
  // ********
  // A resistor pin sits between both thresholds
  always_comb begin
    for (int i = 0; i < `MPCL_NPIN; i++) begin
      pinLowLvl[i] = pinKind[2*i +: 2] == K_LOW;
      pinHighLvl[i] = pinKind[2*i +: 2] == K_HIGH;
      pinResCode[5*i +: 5] = (pinKind[2*i +: 2] == K_RES) ? pinCode[5*i +: 5] : 5'h00;
    end
  end
  // ********
  // Store
  // ********
  logic [31:0] word_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      storeHasData <= 1'b0;
    end else if (storeWrite) begin
      storeHasData <= 1'b1;
      word_q <= storeWrData;
    end
  end
  // Unwritten store reads back garbage
  assign storeRdData = storeHasData ? word_q : ~word_q;
endmodule // mpcl_front_model
`default_nettype wire

// *** dv/mpcl_loader_checker.sv ***
// Port assertions for the pin configuration loader
// Assumes binding into mpcl_loader
`default_nettype none
`include "mpcl_regs.svh"
module mpcl_loader_checker
  import mpcl_pkg::*;
#(
  parameter int MEMCHECK_US = 2
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        enableReqPin,
  input wire logic        storeWrite,
  input wire logic [6:0]  busAddress,
  input wire logic [15:0] voutSetMv,
  input wire logic [15:0] voutCeilMv,
  input wire logic        convertEnable,
  input wire logic        configReady
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Wait counter
  // ********
  localparam int CheckCycles = MEMCHECK_US * 40;
  logic [31:0] waitCnt_q;
  always_ff @(posedge clock) begin
    if (reset || configReady) begin
      waitCnt_q <= 32'h0;
    end else begin
      waitCnt_q <= waitCnt_q + 32'h1;
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence accessSeq;
    psel && penable;
  endsequence
  sequence ctrlWrSeq(pos);
    accessSeq ##0 pwrite && paddr == `MPCL_OFF_CTRL && pwdata[pos] && configReady;
  endsequence
  ready_wait_a: assert property ($rose(configReady) |-> waitCnt_q >= CheckCycles)
    else $error("ready before check end");
  bus_refuse_a: assert property (accessSeq ##0 !configReady |-> pslverr && prdata == 32'h0)
    else $error("bus served during check");
  pready_a: assert property (pready == (psel && penable))
    else $error("pready outside access");
  enable_gate_a: assert property (convertEnable |-> configReady)
    else $error("converter enabled before ready");
  enable_sync_a: assert property (configReady && $past(configReady) |->
    convertEnable == $past(enableReqPin, 2)) else $error("enable lags pin wrongly");
  pins_hold_a: assert property (configReady && $past(configReady) |->
    $stable(busAddress) && $stable(voutCeilMv)) else $error("pin settings moved");
  vout_cap_a: assert property (configReady |-> voutSetMv <= voutCeilMv)
    else $error("setpoint above ceiling");
  save_pulse_a: assert property (ctrlWrSeq(`MPCL_CTRL_SAVE) |=> storeWrite ##1 !storeWrite)
    else $error("no single store pulse");
  restore_drop_a: assert property (ctrlWrSeq(`MPCL_CTRL_RESTORE) |=> !configReady [*3])
    else $error("restore kept ready");
endmodule // mpcl_loader_checker
bind mpcl_loader mpcl_loader_checker #(.MEMCHECK_US(MEMCHECK_US)) mpcl_loader_checker_inst (
  .clock(clock), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .enableReqPin(enableReqPin), .storeWrite(storeWrite), .busAddress(busAddress),
  .voutSetMv(voutSetMv), .voutCeilMv(voutCeilMv), .convertEnable(convertEnable),
  .configReady(configReady)
);
`default_nettype wire

// *** dv/mpcl_loader_bench.sv ***
// Self-checking bench for the pin configuration loader
// Assumes the front end model and a shortened memory check
`default_nettype none
`include "mpcl_regs.svh"
module mpcl_loader_bench
  import mpcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MemUs = 2;
  localparam logic [15:0] LoMv [10] = '{16'h0258, 16'h02bc, 16'h02ee, 16'h0320, 16'h0384,
    16'h03e8, 16'h044c, 16'h04b0, 16'h04e2, 16'h0514};
  localparam logic [15:0] StrapMv [3] = '{16'h04b0, 16'h05dc, 16'h0ce4};
  logic        clock, reset, psel, penable, pwrite, enableReqPin, pready, pslverr;
  logic        storeHasData, storeWrite, convertEnable, configReady, irq, rerr;
  logic [7:0]  paddr, softStartCfg;
  logic [31:0] pwdata, prdata, storeRdData, storeWrData, rdata;
  logic [2:0]  pinLowLvl, pinHighLvl;
  logic [14:0] pinResCode, pinCode;
  logic [5:0]  pinKind;
  logic [6:0]  busAddress;
  logic [15:0] voutMeasMv, voutSetMv, voutCeilMv;
  int          n_errors = 0, total_checks = 0, cyc = 0, relCyc = 0;
  mpcl_loader #(.MEMCHECK_US(MemUs)) mpcl_loader_inst (
    .clock(clock), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinLowLvl(pinLowLvl), .pinHighLvl(pinHighLvl), .pinResCode(pinResCode),
    .enableReqPin(enableReqPin), .voutMeasMv(voutMeasMv), .storeHasData(storeHasData),
    .storeRdData(storeRdData), .storeWrite(storeWrite), .storeWrData(storeWrData),
    .busAddress(busAddress), .voutSetMv(voutSetMv), .voutCeilMv(voutCeilMv),
    .softStartCfg(softStartCfg), .convertEnable(convertEnable),
    .configReady(configReady), .irq(irq));
  mpcl_front_model mpcl_front_model_inst (
    .clock(clock), .reset(reset), .pinKind(pinKind), .pinCode(pinCode),
    .storeWrite(storeWrite), .storeWrData(storeWrData), .pinLowLvl(pinLowLvl),
    .pinHighLvl(pinHighLvl), .pinResCode(pinResCode), .storeHasData(storeHasData),
    .storeRdData(storeRdData));
  // ********
  // Clock and watchdog
  // ********
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // Thirty-six loads, bus traffic, margin
  initial begin
    repeat (20000) @(posedge clock);
    $display("CHECK FAILED %0t watchdog expired", $time);
    n_errors++;
    results();
  end
  // ********
  // Helpers
  // ********
  task automatic results();
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  function automatic logic [15:0] resMv(input int i);
    if (i < 10) return LoMv[i];
    if (i < 30) return 16'h0578 + 16'(i - 10) * 16'h0064;
    return 16'h1388;
  endfunction
  function automatic logic [15:0] ceilMv(input logic [15:0] v);
    return 16'((32'(v) * `MPCL_CEIL_NUM) / `MPCL_CEIL_DEN);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk(32'(n < 16), 32'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
    chk(32'(rerr), 32'(err));
  endtask
  task automatic waitReady();
    int n = 0;
    while (configReady !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n < 400), 32'h1);
  endtask
  task automatic restore();
    wr(`MPCL_OFF_CTRL, 32'h1);
    repeat (2) @(posedge clock);
    waitReady();
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_memcheck();
    wr(`MPCL_OFF_SSCFG, 32'h5a);
    chk(32'(rerr), 32'h1);
    rd(`MPCL_OFF_STATUS, 32'h0, 1'b1);
    chk(32'(convertEnable), 32'h0);
    waitReady();
    chk(32'((cyc - relCyc) >= MemUs * 40), 32'h1);
    rd(`MPCL_OFF_SSCFG, 32'h0, 1'b0);
  endtask
  task automatic t_strap();
    for (int k = 0; k < 3; k++) begin
      pinKind <= {K_LOW, 2'(k), 2'(k)};
      restore();
      rd(`MPCL_OFF_ADDR, 32'(`MPCL_ADDR_BASE + 7'(k)), 1'b0);
      rd(`MPCL_OFF_VOUT, 32'(StrapMv[k]), 1'b0);
      rd(`MPCL_OFF_VCEIL, 32'(ceilMv(StrapMv[k])), 1'b0);
      apb(1'b0, `MPCL_OFF_STATUS, 32'h0);
      chk(32'({rdata[9:4], rdata[1:0]}), 32'({pinKind, 2'b11}));
    end
  endtask
  task automatic t_resistor();
    pinKind <= {3{K_RES}};
    for (int n = 1; n < 32; n++) begin
      pinCode <= {3{5'(n)}};
      restore();
      rd(`MPCL_OFF_ADDR, 32'(`MPCL_ADDR_BASE + `MPCL_ADDR_RES_OFS + 7'(n - 1)), 1'b0);
      rd(`MPCL_OFF_VOUT, 32'(resMv(n - 1)), 1'b0);
      chk(32'(voutCeilMv), 32'(ceilMv(resMv(n - 1))));
      chk(32'(softStartCfg[6:5]), 32'(K_RES));
    end
    pinKind <= {3{K_HIGH}};
    pinCode <= 15'h0421;
    repeat (10) @(posedge clock);
    chk(32'(busAddress), 32'h41);
    rd(`MPCL_OFF_VOUT, 32'h1388, 1'b0);
    chk(32'(convertEnable), 32'h1);
    enableReqPin <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'(convertEnable), 32'h0);
  endtask
  task automatic t_host();
    wr(`MPCL_OFF_VOUT, 32'h04d2);
    @(posedge clock);
    chk(32'(voutSetMv), 32'h04d2);
    rd(`MPCL_OFF_VOUT, 32'h04d2, 1'b0);
    wr(`MPCL_OFF_ADDR, 32'h55);
    wr(`MPCL_OFF_VCEIL, 32'h0);
    rd(`MPCL_OFF_ADDR, 32'h41, 1'b0);
    rd(`MPCL_OFF_VCEIL, 32'h157c, 1'b0);
    wr(`MPCL_OFF_SSCFG, 32'ha5);
    rd(`MPCL_OFF_SSCFG, 32'ha5, 1'b0);
    rd(8'h30, 32'h0, 1'b1);
    rd(`MPCL_OFF_UVTH, 32'(`MPCL_UV_RESET), 1'b0);
    rd(`MPCL_OFF_OVTH, 32'(`MPCL_OV_RESET), 1'b0);
    wr(`MPCL_OFF_VOUT, 32'h1770);
    rd(`MPCL_OFF_VOUT, 32'h157c, 1'b0);
    rd(`MPCL_OFF_IRQSTAT, 32'h9, 1'b0);
    chk(32'(irq), 32'h0);
    wr(`MPCL_OFF_IRQMASK, 32'h8);
    rd(`MPCL_OFF_IRQMASK, 32'h8, 1'b0);
    chk(32'(irq), 32'h1);
    wr(`MPCL_OFF_IRQSTAT, 32'h8);
    @(posedge clock);
    chk(32'(irq), 32'h0);
    wr(`MPCL_OFF_UVTH, 32'h07d0);
    wr(`MPCL_OFF_IRQMASK, 32'h2);
    @(posedge clock);
    chk(32'(irq), 32'h1);
    wr(`MPCL_OFF_OVTH, 32'h0100);
    rd(`MPCL_OFF_IRQSTAT, 32'h7, 1'b0);
    wr(`MPCL_OFF_OVTH, 32'hffff);
    wr(`MPCL_OFF_UVTH, 32'h0);
    wr(`MPCL_OFF_IRQSTAT, 32'hf);
    @(posedge clock);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_store();
    wr(`MPCL_OFF_VOUT, 32'h0708);
    wr(`MPCL_OFF_SSCFG, 32'h33);
    wr(`MPCL_OFF_CTRL, 32'h2);
    @(posedge clock);
    chk(storeWrData, 32'h00330708);
    wr(`MPCL_OFF_VOUT, 32'h0384);
    chk(32'(storeHasData), 32'h1);
    restore();
    rd(`MPCL_OFF_VOUT, 32'h0708, 1'b0);
    rd(`MPCL_OFF_SSCFG, 32'h33, 1'b0);
    rd(`MPCL_OFF_ADDR, 32'h22, 1'b0);
    chk(32'(voutCeilMv), 32'(ceilMv(16'h0ce4)));
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pinKind = {K_LOW, K_OPEN, K_HIGH};
    pinCode = 15'h0000;
    enableReqPin = 1'b1;
    voutMeasMv = 16'h03e8;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    relCyc = cyc;
    t_memcheck();
    t_strap();
    t_resistor();
    t_host();
    t_store();
    results();
  end
endmodule // mpcl_loader_bench
`default_nettype wire
